/* File: rtl/lbr_pkg.sv */
// Shared constants, register map and types of the inductive button readout
package lbr_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam int NUM_CH = 4;
  localparam int RAW_BYTES = 3;

  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_OUT = 8'h01;
  localparam logic [7:0] REG_CHANNEL0_RESULT_LOW = 8'h02;
  localparam logic [7:0] REG_RESET = 8'h0A;
  localparam logic [7:0] REG_EN = 8'h0C;
  localparam logic [7:0] REG_CHANNEL0_GAIN = 8'h0E;
  localparam logic [7:0] REG_CHANNEL1_GAIN = 8'h10;
  localparam logic [7:0] REG_IRQ_POLARITY_AND_ALGO_SELECT = 8'h11;
  localparam logic [7:0] REG_CHANNEL2_GAIN = 8'h12;
  localparam logic [7:0] REG_CHANNEL3_GAIN = 8'h14;
  localparam logic [7:0] REG_SAMPLE = 8'h17;
  localparam logic [7:0] REG_POL = 8'h1C;
  localparam logic [7:0] REG_RAW_BASE = 8'h20;

  localparam int CFG_MODE_BIT = 0;
  localparam int IRQ_POL_BIT = 0;
  localparam int ALGO_BIT = 1;
  localparam int STAT_WP_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_CFG_BIT = 2;
  localparam int OUT_RDY_BIT = 7;

  localparam logic [7:0] RESET_RST = 8'h00;
  localparam logic [7:0] EN_RST = 8'h01;
  localparam logic [5:0] GAIN_RST = 6'h10;
  localparam logic [7:0] IRQ_POLARITY_AND_ALGO_SELECT_RST = 8'h02;
  localparam logic [7:0] SAMPLE_RST = 8'h03;
  localparam logic [7:0] POL_RST = 8'h0F;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SCAN_PERIOD_US = 12500;
  localparam int SCAN_CYCLES = SCAN_PERIOD_US * 1000 / CLK_PERIOD_NS;

  localparam int W_BASE_SHIFT = 7;
  localparam logic [4:0] CONV_MULT = 5'h1E;
  localparam logic signed [11:0] PRESS_THRESH = 12'sh040;
  localparam int BASE_SHIFT = 4;
  localparam int GAIN_NORM_SHIFT = 3;
  localparam logic [10:0] GAIN_MAX_X8 = 11'h740;

  typedef enum logic [6:0] {
    I2C_IDLE = 7'b0000001,
    I2C_ADDR = 7'b0000010,
    I2C_ACK = 7'b0000100,
    I2C_PTR = 7'b0001000,
    I2C_WR = 7'b0010000,
    I2C_RD = 7'b0100000,
    I2C_RACK = 7'b1000000
  } lbr_i2c_state_type;

  typedef enum logic [3:0] {
    SC_HALT = 4'b0001,
    SC_WAIT = 4'b0010,
    SC_CONV = 4'b0100,
    SC_PROC = 4'b1000
  } lbr_scan_state_type;

  typedef struct packed {
    logic valid;
    logic err;
    logic [23:0] raw;
  } lbr_conv_res_type;

  typedef struct packed {
    logic stb;
    logic [7:0] addr;
    logic [7:0] data;
  } lbr_bus_evt_type;
endpackage : lbr_pkg

/* File: rtl/lbr_conv.sv */
// Frequency-to-digital converter for one sensor at a time
module lbr_conv (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic osc,
  input wire logic [18:0] window,
  output lbr_pkg::lbr_conv_res_type res
);
  logic osc_q;
  logic armed_q;
  logic counting_q;
  logic [18:0] per_q;
  logic [23:0] ref_q;
  logic [28:0] scaled;
  logic osc_rise;

  assign osc_rise = osc & ~osc_q;
  // Raw value is 30 reference ticks for each tick counted over W periods
  assign scaled = 29'(ref_q) * 29'(lbr_pkg::CONV_MULT);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      osc_q <= 1'b0;
      armed_q <= 1'b0;
      counting_q <= 1'b0;
      per_q <= 19'h00000;
      ref_q <= 24'h000000;
      res <= '0;
    end
    else
    begin
      osc_q <= osc;
      res.valid <= 1'b0;
      if (abort)
      begin
        armed_q <= 1'b0;
        counting_q <= 1'b0;
      end
      else if (start)
      begin
        armed_q <= 1'b1;
        counting_q <= 1'b0;
        per_q <= 19'h00000;
        ref_q <= 24'h000000;
      end
      else if (armed_q)
      begin
        if (counting_q)
          ref_q <= ref_q + 24'h000001;
        // A sensor that stops after its first rising edge saturates the count and is reported as an error
        if (&ref_q)
        begin
          armed_q <= 1'b0;
          res <= '{valid: 1'b1, err: 1'b1, raw: 24'hFFFFFF};
        end
        else if (osc_rise)
        begin
          counting_q <= 1'b1;
          if (counting_q)
            per_q <= per_q + 19'h00001;
          if (counting_q && per_q == window - 19'h00001)
          begin
            armed_q <= 1'b0;
            res.valid <= 1'b1;
            res.err <= 1'b0;
            res.raw <= (|scaled[28:24]) ? 24'hFFFFFF : scaled[23:0];
          end
        end
      end
    end
  end
endmodule : lbr_conv

/* File: rtl/lbr_top.sv */
// Four-channel inductive button readout with I2C register access
// How it works
// - IRQ_POLARITY_AND_ALGO_SELECT bit 1 zero selects raw-data operation, one selects button algorithm
// - Raw operation exposes converter output with no tracking or thresholds
// - Algorithm operation fills processed registers and drives button pins
// - Each channel has enable and low-power enable; low-power needs enable
// - Active channels are converted one after another each scan
// - OUT data-ready bit flags a fresh result
// - In raw operation each new result asserts the interrupt line
// - Each raw result is 24 bits over three byte registers
// - Raw equals 30 times W reference ticks per sensor period count
// - Button pins are push-pull with per-pin programmable polarity
// - Open-drain interrupt on press or error, polarity selectable
// - Reading status clears any interrupt assertion
// - OUT holds four per-channel press flags
// - Processed value is 12-bit two's complement with selectable sign
// - Gain selects 64 levels from 1 to about 232
// - Baseline tracking runs in algorithm operation and pauses while the channel detects a press
// - Opposite or common neighbour responses suppress a press
// - Fixed 7-bit target address followed by an 8-bit pointer
// - Pointer auto-increments while the controller acknowledges
// - A new scan starts within 1 ms of leaving config mode
// - Config mode halts conversions until it is cleared
// - The clock line is never driven
module lbr_top #(
  parameter int SCAN_CYCLES = lbr_pkg::SCAN_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq_line_o,
  output logic irq_line_oe,
  output logic [3:0] button_pin,
  input wire logic [3:0] sensor_osc,
  input wire logic low_power_sel
);
  lbr_pkg::lbr_i2c_state_type st_q;
  lbr_pkg::lbr_i2c_state_type after_q;
  lbr_pkg::lbr_scan_state_type sc_q;
  lbr_pkg::lbr_bus_evt_type wr_q;
  lbr_pkg::lbr_bus_evt_type rd_q;
  lbr_pkg::lbr_conv_res_type res;
  logic scl_q, sda_q, acked_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, ptr_q, rd_byte;
  logic [7:0] reset_q, en_q, irq_polarity_and_algo_select_q, sample_q, pol_q;
  logic [5:0] gain_q [lbr_pkg::NUM_CH];
  logic [23:0] raw_q [lbr_pkg::NUM_CH];
  logic [23:0] base_q [lbr_pkg::NUM_CH];
  logic [11:0] proc_q [lbr_pkg::NUM_CH];
  logic [23:0] snap_raw_q [lbr_pkg::NUM_CH];
  logic [11:0] snap_proc_q [lbr_pkg::NUM_CH];
  logic [3:0] base_ok_q, press_q, snap_press_q;
  logic rdy_q, err_q, irq_q, conv_start_q;
  logic [1:0] ch_q;
  logic [31:0] tick_q;
  logic scl_rise, scl_fall, start_c, stop_c, cfg_mode, algo, wp, tick;
  logic [3:0] active, nxt_mask;
  logic [18:0] window;

  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_c = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_c = scl_i & scl_q & ~sda_q & sda_i;
  assign cfg_mode = reset_q[lbr_pkg::CFG_MODE_BIT];
  assign algo = irq_polarity_and_algo_select_q[lbr_pkg::ALGO_BIT];
  assign wp = cfg_mode && sc_q == lbr_pkg::SC_HALT;
  // Low-power enable only counts when the channel enable is also set
  assign active = low_power_sel ? (en_q[3:0] & en_q[7:4]) : en_q[3:0];
  assign window = (19'(sample_q[3:0]) + 19'h00001)
    << (lbr_pkg::W_BASE_SHIFT + int'(sample_q[6:4]));
  assign tick = tick_q == 32'h00000000;

  // I2C target; outputs change only on clock falling edges
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      st_q <= lbr_pkg::I2C_IDLE;
      after_q <= lbr_pkg::I2C_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      acked_q <= 1'b0;
      sda_oe <= 1'b0;
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      wr_q.stb <= 1'b0;
      rd_q.stb <= 1'b0;
      if (start_c)
      begin
        st_q <= lbr_pkg::I2C_ADDR;
        cnt_q <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (stop_c)
      begin
        st_q <= lbr_pkg::I2C_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        unique case (st_q)
          lbr_pkg::I2C_IDLE: ;
          lbr_pkg::I2C_ADDR, lbr_pkg::I2C_PTR, lbr_pkg::I2C_WR:
          begin
            if (scl_rise)
            begin
              shift_q <= {shift_q[6:0], sda_i};
              cnt_q <= cnt_q + 4'h1;
            end
            else if (scl_fall && cnt_q == 4'h8)
            begin
              cnt_q <= 4'h0;
              st_q <= lbr_pkg::I2C_ACK;
              sda_oe <= 1'b1;
              if (st_q == lbr_pkg::I2C_ADDR)
              begin
                after_q <= shift_q[0] ? lbr_pkg::I2C_RD : lbr_pkg::I2C_PTR;
                if (shift_q[7:1] != lbr_pkg::DEV_ADDR)
                begin
                  st_q <= lbr_pkg::I2C_IDLE;
                  sda_oe <= 1'b0;
                end
              end
              else if (st_q == lbr_pkg::I2C_PTR)
              begin
                ptr_q <= shift_q;
                after_q <= lbr_pkg::I2C_WR;
              end
              else
              begin
                wr_q <= '{stb: 1'b1, addr: ptr_q, data: shift_q};
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          lbr_pkg::I2C_ACK, lbr_pkg::I2C_RACK:
          begin
            if (scl_rise)
              acked_q <= ~sda_i;
            else if (scl_fall)
            begin
              sda_oe <= 1'b0;
              st_q <= after_q;
              if (after_q == lbr_pkg::I2C_RD)
              begin
                if (st_q == lbr_pkg::I2C_RACK && !acked_q)
                  st_q <= lbr_pkg::I2C_IDLE;
                else
                begin
                  shift_q <= rd_byte;
                  sda_oe <= ~rd_byte[7];
                  rd_q <= '{stb: 1'b1, addr: ptr_q, data: rd_byte};
                  ptr_q <= ptr_q + 8'h01;
                  cnt_q <= 4'h0;
                end
              end
            end
          end
          lbr_pkg::I2C_RD:
          begin
            if (scl_rise)
              cnt_q <= cnt_q + 4'h1;
            else if (scl_fall)
            begin
              if (cnt_q == 4'h8)
              begin
                sda_oe <= 1'b0;
                st_q <= lbr_pkg::I2C_RACK;
              end
              else
              begin
                shift_q <= {shift_q[6:0], 1'b0};
                sda_oe <= ~shift_q[6];
              end
            end
          end
        endcase
      end
    end
  end

  // Register read view; result registers come from the status-read snapshot
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (ptr_q)
      lbr_pkg::REG_STATUS:
        rd_byte = 8'({cfg_mode, err_q, wp}) << lbr_pkg::STAT_WP_BIT;
      lbr_pkg::REG_OUT: rd_byte = {rdy_q, 3'h0, snap_press_q};
      lbr_pkg::REG_RESET: rd_byte = reset_q;
      lbr_pkg::REG_EN: rd_byte = en_q;
      lbr_pkg::REG_CHANNEL0_GAIN: rd_byte = {2'h0, gain_q[0]};
      lbr_pkg::REG_CHANNEL1_GAIN: rd_byte = {2'h0, gain_q[1]};
      lbr_pkg::REG_CHANNEL2_GAIN: rd_byte = {2'h0, gain_q[2]};
      lbr_pkg::REG_CHANNEL3_GAIN: rd_byte = {2'h0, gain_q[3]};
      lbr_pkg::REG_IRQ_POLARITY_AND_ALGO_SELECT: rd_byte = irq_polarity_and_algo_select_q;
      lbr_pkg::REG_SAMPLE: rd_byte = sample_q;
      lbr_pkg::REG_POL: rd_byte = pol_q;
      default:
        for (int n = 0; n < lbr_pkg::NUM_CH; n++)
        begin
          if (ptr_q == lbr_pkg::REG_CHANNEL0_RESULT_LOW + 8'(2 * n))
            rd_byte = snap_proc_q[n][7:0];
          if (ptr_q == lbr_pkg::REG_CHANNEL0_RESULT_LOW + 8'(2 * n + 1))
            rd_byte = {4'h0, snap_proc_q[n][11:8]};
          for (int x = 0; x < lbr_pkg::RAW_BYTES; x++)
            if (ptr_q == lbr_pkg::REG_RAW_BASE + 8'(lbr_pkg::RAW_BYTES * n + x))
              rd_byte = snap_raw_q[n][8 * (2 - x) +: 8];
        end
    endcase
  end

  // Settings registers; only the reset register is writable outside config
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reset_q <= lbr_pkg::RESET_RST;
      en_q <= lbr_pkg::EN_RST;
      irq_polarity_and_algo_select_q <= lbr_pkg::IRQ_POLARITY_AND_ALGO_SELECT_RST;
      sample_q <= lbr_pkg::SAMPLE_RST;
      pol_q <= lbr_pkg::POL_RST;
      for (int n = 0; n < lbr_pkg::NUM_CH; n++)
        gain_q[n] <= lbr_pkg::GAIN_RST;
    end
    else if (wr_q.stb)
    begin
      if (wr_q.addr == lbr_pkg::REG_RESET)
        reset_q <= wr_q.data;
      else if (wp)
      begin
        unique case (wr_q.addr)
          lbr_pkg::REG_EN: en_q <= wr_q.data;
          lbr_pkg::REG_IRQ_POLARITY_AND_ALGO_SELECT: irq_polarity_and_algo_select_q <= wr_q.data;
          lbr_pkg::REG_SAMPLE: sample_q <= wr_q.data;
          lbr_pkg::REG_POL: pol_q <= wr_q.data;
          lbr_pkg::REG_CHANNEL0_GAIN: gain_q[0] <= wr_q.data[5:0];
          lbr_pkg::REG_CHANNEL1_GAIN: gain_q[1] <= wr_q.data[5:0];
          lbr_pkg::REG_CHANNEL2_GAIN: gain_q[2] <= wr_q.data[5:0];
          lbr_pkg::REG_CHANNEL3_GAIN: gain_q[3] <= wr_q.data[5:0];
          default: ;
        endcase
      end
    end
  end

  // Scan rate divider; restarts at once when config mode ends
  always_ff @(posedge clk)
  begin
    if (rst || sc_q == lbr_pkg::SC_HALT)
      tick_q <= 32'h00000000;
    else if (tick)
      tick_q <= 32'(SCAN_CYCLES - 1);
    else
      tick_q <= tick_q - 32'h00000001;
  end

  lbr_conv u_conv (
    .clk(clk),
    .rst(rst),
    .start(conv_start_q),
    .abort(cfg_mode),
    .osc(sensor_osc[ch_q]),
    .window(window),
    .res(res)
  );

  // Processing of the channel just converted
  logic signed [24:0] diff;
  logic [10:0] gain_x8;
  logic signed [36:0] prod;
  logic signed [11:0] val;
  logic signed [11:0] nb_lo, nb_hi;
  logic hit;
  always_comb
  begin
    diff = $signed({1'b0, base_q[ch_q]}) - $signed({1'b0, raw_q[ch_q]});
    // Exponent-mantissa gain gives roughly 9% per step up to the cap
    gain_x8 = 11'({7'h01, gain_q[ch_q][2:0]}) << gain_q[ch_q][5:3];
    if (gain_x8 > lbr_pkg::GAIN_MAX_X8)
      gain_x8 = lbr_pkg::GAIN_MAX_X8;
    prod = (37'(diff) * $signed({26'h0, gain_x8})) >>> lbr_pkg::GAIN_NORM_SHIFT;
    if (prod > 37'sh7FF)
      val = 12'sh7FF;
    else if (prod < -37'sh800)
      val = -12'sh800;
    else
      val = prod[11:0];
    nb_lo = proc_q[ch_q - 2'h1];
    nb_hi = proc_q[ch_q + 2'h1];
    // Opposite neighbour or both neighbours alike point to crosstalk
    hit = val > lbr_pkg::PRESS_THRESH
      && !(nb_lo < -lbr_pkg::PRESS_THRESH || nb_hi < -lbr_pkg::PRESS_THRESH)
      && !(nb_lo > lbr_pkg::PRESS_THRESH && nb_hi > lbr_pkg::PRESS_THRESH);
    nxt_mask = active & ~((4'h2 << ch_q) - 4'h1);
  end

  // Scan sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sc_q <= lbr_pkg::SC_HALT;
      ch_q <= 2'h0;
      conv_start_q <= 1'b0;
    end
    else
    begin
      conv_start_q <= 1'b0;
      if (cfg_mode)
        sc_q <= lbr_pkg::SC_HALT;
      else
      begin
        unique case (sc_q)
          lbr_pkg::SC_HALT: sc_q <= lbr_pkg::SC_WAIT;
          lbr_pkg::SC_WAIT:
            if (tick && |active)
            begin
              ch_q <= active[0] ? 2'h0 : active[1] ? 2'h1 : active[2] ? 2'h2 : 2'h3;
              conv_start_q <= 1'b1;
              sc_q <= lbr_pkg::SC_CONV;
            end
          lbr_pkg::SC_CONV:
            if (res.valid)
              sc_q <= lbr_pkg::SC_PROC;
          lbr_pkg::SC_PROC:
            if (|nxt_mask)
            begin
              ch_q <= nxt_mask[1] ? 2'h1 : nxt_mask[2] ? 2'h2 : 2'h3;
              conv_start_q <= 1'b1;
              sc_q <= lbr_pkg::SC_CONV;
            end
            else
              sc_q <= lbr_pkg::SC_WAIT;
        endcase
      end
    end
  end

  // Result store, baseline tracking and press decision
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      base_ok_q <= 4'h0;
      press_q <= 4'h0;
      for (int n = 0; n < lbr_pkg::NUM_CH; n++)
      begin
        raw_q[n] <= 24'h000000;
        base_q[n] <= 24'h000000;
        proc_q[n] <= 12'h000;
      end
    end
    else if (sc_q == lbr_pkg::SC_CONV && res.valid)
      raw_q[ch_q] <= res.raw;
    else if (sc_q == lbr_pkg::SC_PROC && algo)
    begin
      proc_q[ch_q] <= pol_q[4 + ch_q] ? -val : val;
      press_q[ch_q] <= hit;
      if (!base_ok_q[ch_q])
      begin
        base_ok_q[ch_q] <= 1'b1;
        base_q[ch_q] <= raw_q[ch_q];
      end
      else if (!hit)
        base_q[ch_q] <= 24'($signed({1'b0, base_q[ch_q]}) - (diff >>> lbr_pkg::BASE_SHIFT));
    end
    else if (!algo)
      press_q <= 4'h0;
  end

  // Flags, interrupt and snapshot taken by a status read
  logic new_res, press_new, stat_rd, out_rd;
  assign new_res = sc_q == lbr_pkg::SC_PROC;
  assign press_new = new_res && algo && hit && !press_q[ch_q];
  assign stat_rd = rd_q.stb && rd_q.addr == lbr_pkg::REG_STATUS;
  assign out_rd = rd_q.stb && rd_q.addr == lbr_pkg::REG_OUT;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      irq_q <= 1'b0;
      snap_press_q <= 4'h0;
      for (int n = 0; n < lbr_pkg::NUM_CH; n++)
      begin
        snap_raw_q[n] <= 24'h000000;
        snap_proc_q[n] <= 12'h000;
      end
    end
    else
    begin
      rdy_q <= new_res | (rdy_q & ~out_rd);
      err_q <= (res.valid & res.err) | (err_q & ~stat_rd);
      irq_q <= (new_res & ~algo) | press_new | (res.valid & res.err)
        | (irq_q & ~stat_rd);
      if (stat_rd)
      begin
        snap_press_q <= press_q;
        for (int n = 0; n < lbr_pkg::NUM_CH; n++)
        begin
          snap_raw_q[n] <= raw_q[n];
          snap_proc_q[n] <= proc_q[n];
        end
      end
    end
  end

  // Pins: open-drain lines drive low only; push-pull buttons follow polarity
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sda_o <= 1'b0;
      irq_line_o <= 1'b0;
      irq_line_oe <= 1'b0;
      button_pin <= 4'h0;
    end
    else
    begin
      sda_o <= 1'b0;
      irq_line_o <= 1'b0;
      irq_line_oe <= irq_q ^ irq_polarity_and_algo_select_q[lbr_pkg::IRQ_POL_BIT];
      button_pin <= ~(press_q ^ pol_q[3:0]);
    end
  end
endmodule : lbr_top

/* File: verif/lbr_checker.sv */
// Port-level assertions of the inductive button readout
module lbr_checker #(
  parameter int SCAN_CYCLES = 2000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic irq_line_o,
  input wire logic irq_line_oe,
  input wire logic [3:0] button_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_SDA_OPEN_DRAIN: assert property (sda_oe |-> !sda_o)
    else $error("sda driven high");
  AST_IRQ_OPEN_DRAIN: assert property (irq_line_oe |-> !irq_line_o)
    else $error("irq line driven high");
  AST_SDA_AFTER_FALL: assert property ($changed(sda_oe) |-> $past(scl_i, 2) && !$past(scl_i))
    else $error("sda changed away from a clock fall");
  AST_SDA_STILL_SCL_HIGH: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("sda moved while clock high");
  AST_ACK_IN_LOW: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("sda pulled with clock high");
  AST_RST_SDA: assert property (disable iff (1'b0) rst |=> !sda_oe)
    else $error("sda held after reset");
  AST_RST_IRQ: assert property (disable iff (1'b0) rst |=> !irq_line_oe)
    else $error("irq held after reset");
  AST_RST_PINS: assert property (disable iff (1'b0) rst |=> button_pin == 4'h0)
    else $error("button pins not idle after reset");
  cover property ($rose(sda_oe));
  cover property ($rose(irq_line_oe));
  cover property (button_pin != 4'h0);
endmodule : lbr_checker

/* File: verif/lbr_host.sv */
// I2C host controller model for the readout bus
module lbr_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 8;
  logic [7:0] rd [16];
  logic nak;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hw();
    repeat (HALF) @(negedge clk);
  endtask : hw
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    hw();
    scl = 1'b1;
    s = sda;
    hw();
    scl = 1'b0;
  endtask : bit_io
  task automatic start();
    sda_low = 1'b0;
    hw();
    scl = 1'b1;
    hw();
    sda_low = 1'b1;
    hw();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    hw();
    scl = 1'b1;
    hw();
    sda_low = 1'b0;
    hw();
  endtask : stop
  task automatic byte_io(input logic [7:0] d, input logic ack_out, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ack_out, nak);
  endtask : byte_io
  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] q;
    start();
    byte_io({dev, 1'b0}, 1'b1, q);
    if (!nak)
    begin
      byte_io(ptr, 1'b1, q);
      byte_io(d, 1'b1, q);
    end
    stop();
  endtask : wr_reg
  task automatic rd_regs(input logic [7:0] ptr, input int n);
    logic [7:0] q;
    start();
    byte_io({lbr_pkg::DEV_ADDR, 1'b0}, 1'b1, q);
    byte_io(ptr, 1'b1, q);
    start();
    byte_io({lbr_pkg::DEV_ADDR, 1'b1}, 1'b1, q);
    for (int i = 0; i < n; i++)
      byte_io(8'hFF, i == n - 1, rd[i]);
    stop();
  endtask : rd_regs
endmodule : lbr_host

/* File: verif/testbench.sv */
// Self-checking bench of the inductive button readout
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SCAN = 2000;
  logic clk, rst, low_power_sel, sda_o, sda_oe, irq_line_o, irq_line_oe, scl, sda_low;
  logic [3:0] button_pin, sensor_osc;
  logic [7:0] en;
  wire logic sda;
  int failures, comparisons, seed, k, raw, want, per[4], cnt[4], mdl[256];
  assign sda = !(sda_low || sda_oe);
  lbr_top #(.SCAN_CYCLES(SCAN)) u_lbr_top (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .irq_line_o(irq_line_o), .irq_line_oe(irq_line_oe),
    .button_pin(button_pin), .sensor_osc(sensor_osc), .low_power_sel(low_power_sel));
  lbr_host u_lbr_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Sensor oscillators with a period of per[n] clocks
  always @(negedge clk)
    for (int n = 0; n < 4; n++)
      if (++cnt[n] >= per[n] / 2)
      begin
        cnt[n] = 0;
        sensor_osc[n] = ~sensor_osc[n];
      end
  task automatic complete_run();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // Writes reach the model only while the device accepts them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_lbr_host.wr_reg(lbr_pkg::DEV_ADDR, a, d);
    if (a == lbr_pkg::REG_RESET || mdl[lbr_pkg::REG_RESET][0])
      mdl[a] = d;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input int n);
    u_lbr_host.rd_regs(a, n);
    for (int i = 0; i < n; i++)
      if (mdl[a + i] >= 0)
        chk("register", mdl[a + i], u_lbr_host.rd[i]);
  endtask : rdchk
  initial
  begin
    repeat (90000) @(posedge clk);
    failures++;
    complete_run();
  end
  initial
  begin
    seed = 22;
    rst = 1'b1;
    low_power_sel = 1'b0;
    sensor_osc = 4'h0;
    per = '{8, 8, 10, 12};
    for (int i = 0; i < 256; i++)
      mdl[i] = -1;
    mdl[8'h0A] = lbr_pkg::RESET_RST;
    mdl[8'h0C] = lbr_pkg::EN_RST;
    mdl[8'h0E] = lbr_pkg::GAIN_RST;
    mdl[8'h10] = lbr_pkg::GAIN_RST;
    mdl[8'h11] = lbr_pkg::IRQ_POLARITY_AND_ALGO_SELECT_RST;
    mdl[8'h1C] = lbr_pkg::POL_RST;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("pins", 4'h0, button_pin);
    chk("irq", 1'b0, irq_line_oe);
    rdchk(lbr_pkg::REG_RESET, 8);
    rdchk(lbr_pkg::REG_POL, 1);
    wr(lbr_pkg::REG_EN, 8'h0F);
    rdchk(lbr_pkg::REG_EN, 1);
    u_lbr_host.wr_reg(7'h55, lbr_pkg::REG_EN, 8'h0F);
    chk("nak", 1'b1, u_lbr_host.nak);
    repeat (9000) @(negedge clk);
    per[0] = 6;
    for (k = 0; k < 20000 && button_pin !== 4'h1; k++)
      @(negedge clk);
    repeat (2) @(negedge clk);
    chk("pins", 4'h1, button_pin);
    chk("irq", 1'b1, irq_line_oe);
    u_lbr_host.rd_regs(lbr_pkg::REG_STATUS, 4);
    chk("press", 4'h1, u_lbr_host.rd[1][3:0]);
    chk("data", 12'h7FF, {u_lbr_host.rd[3][3:0], u_lbr_host.rd[2]});
    chk("irq", 1'b0, irq_line_oe);
    wr(lbr_pkg::REG_RESET, 8'h01);
    for (k = 0; k < 50; k++)
    begin
      u_lbr_host.rd_regs(lbr_pkg::REG_STATUS, 1);
      if (u_lbr_host.rd[0][lbr_pkg::STAT_WP_BIT] === 1'b1)
        break;
    end
    chk("write permitted", 1'b1, u_lbr_host.rd[0][lbr_pkg::STAT_WP_BIT]);
    chk("config", 1'b1, u_lbr_host.rd[0][lbr_pkg::STAT_CFG_BIT]);
    en = 8'($random(seed));
    en[0] = 1'b1;
    wr(lbr_pkg::REG_EN, en);
    wr(lbr_pkg::REG_IRQ_POLARITY_AND_ALGO_SELECT, 8'h00);
    wr(lbr_pkg::REG_SAMPLE, 8'h00);
    rdchk(lbr_pkg::REG_EN, 1);
    rdchk(lbr_pkg::REG_IRQ_POLARITY_AND_ALGO_SELECT, 1);
    wr(lbr_pkg::REG_RESET, 8'h00);
    for (k = 0; k < 20000 && irq_line_oe !== 1'b1; k++)
      @(negedge clk);
    chk("irq", 1'b1, irq_line_oe);
    repeat (8000) @(negedge clk);
    wr(lbr_pkg::REG_RESET, 8'h01);
    u_lbr_host.rd_regs(lbr_pkg::REG_STATUS, 2);
    chk("ready", 1'b1, u_lbr_host.rd[1][lbr_pkg::OUT_RDY_BIT]);
    repeat (50) @(negedge clk);
    chk("irq", 1'b0, irq_line_oe);
    chk("pins", 4'h0, button_pin);
    u_lbr_host.rd_regs(lbr_pkg::REG_RAW_BASE, 12);
    for (int n = 0; n < 4; n++)
      if (en[n])
      begin
        raw = {u_lbr_host.rd[3 * n], u_lbr_host.rd[3 * n + 1], u_lbr_host.rd[3 * n + 2]};
        want = 30 * 128 * per[n];
        // Two reference ticks of phase slip are allowed
        chk("raw", want, (raw >= want - 60 && raw <= want + 60) ? want : raw);
      end
    // Low-power operation: a channel needs both its enable and low-power bits
    low_power_sel = 1'b1;
    wr(lbr_pkg::REG_EN, 8'h0E);
    wr(lbr_pkg::REG_RESET, 8'h00);
    repeat (3000) @(negedge clk);
    chk("irq", 1'b0, irq_line_oe);
    wr(lbr_pkg::REG_RESET, 8'h01);
    wr(lbr_pkg::REG_EN, 8'h11);
    wr(lbr_pkg::REG_RESET, 8'h00);
    for (k = 0; k < 5000 && irq_line_oe !== 1'b1; k++)
      @(negedge clk);
    chk("irq", 1'b1, irq_line_oe);
    complete_run();
  end
endmodule : testbench
bind lbr_top lbr_checker #(.SCAN_CYCLES(SCAN_CYCLES)) u_lbr_checker (.clk(clk), .rst(rst),
  .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq_line_o(irq_line_o),
  .irq_line_oe(irq_line_oe), .button_pin(button_pin));
